// ==== pkg/timer8_consts.svh ====
// constants of the asynchronous 8-bit timer: offsets, fields, resets, taps
`ifndef TIMER8_CONSTS_SVH
`define TIMER8_CONSTS_SVH

// ************************************************************
// register byte offsets
// ************************************************************
`define OFF_CONTROL_A 8'h00
`define OFF_CONTROL_B 8'h04
`define OFF_COUNT 8'h08
`define OFF_COMPARE_A 8'h0c
`define OFF_COMPARE_B 8'h10
`define OFF_FLAG 8'h14
`define OFF_MASK 8'h18
`define OFF_ASYNC 8'h1c
`define OFF_POWER 8'h20

// ************************************************************
// field positions
// ************************************************************
`define CA_WGM_LO 0
`define CA_COM_B_LO 4
`define CA_COM_A_LO 6
`define CB_CS_LO 0
`define CB_WGM2 3
`define CB_FOC_B 6
`define CB_FOC_A 7
`define FL_OVERFLOW 0
`define FL_MATCH_A 1
`define FL_MATCH_B 2
`define AS_ASYNC_SEL 3
`define PW_REDUCE 0

// ************************************************************
// values and reset values
// ************************************************************
`define BYTE_ZERO 8'h00
`define BYTE_MAX 8'hff
`define RST_POWER_REDUCE 1'b0

// ************************************************************
// prescaler tap masks (divisor minus one)
// ************************************************************
`define PS_MASK_1 10'h000
`define PS_MASK_8 10'h007
`define PS_MASK_32 10'h01f
`define PS_MASK_64 10'h03f
`define PS_MASK_128 10'h07f
`define PS_MASK_256 10'h0ff
`define PS_MASK_1024 10'h3ff

`endif

// ==== pkg/timer8_pkg.sv ====
// types, mode enum and state structs of the asynchronous 8-bit timer
package timer8_pkg;

  typedef logic [7:0] byte_t;

  // waveform mode codes
  typedef enum logic [2:0] {
    WM_NORMAL = 3'b000,
    WM_PHASE_MAX = 3'b001,
    WM_CTC = 3'b010,
    WM_FAST_MAX = 3'b011,
    WM_RSV4 = 3'b100,
    WM_PHASE_CMP = 3'b101,
    WM_RSV6 = 3'b110,
    WM_FAST_CMP = 3'b111
  } wave_mode_e;

  // prescaler and timer tick state
  typedef struct packed {
    logic osc_prev;
    logic [9:0] prescale;
    logic tick;
  } tick_state_s;

  // one compare channel state
  typedef struct packed {
    byte_t active;
    byte_t buffer;
    logic oc;
  } chan_state_s;

  // top level state
  typedef struct packed {
    byte_t ctrl_a;
    logic [3:0] ctrl_b;
    byte_t count;
    logic dir_down;
    logic block;
    logic [2:0] flags;
    logic [2:0] mask;
    logic async_sel;
    logic power_reduce;
    logic osc_out;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] irq;
  } core_state_s;

  function automatic logic is_fast(input wave_mode_e m);
    return (m == WM_FAST_MAX) || (m == WM_FAST_CMP);
  endfunction : is_fast

  function automatic logic is_phase(input wave_mode_e m);
    return (m == WM_PHASE_MAX) || (m == WM_PHASE_CMP);
  endfunction : is_phase

  function automatic logic top_is_cmp(input wave_mode_e m);
    return (m == WM_CTC) || (m == WM_PHASE_CMP) || (m == WM_FAST_CMP);
  endfunction : top_is_cmp

endpackage : timer8_pkg

// ==== pkg/timer8_links_if.sv ====
// carriers between the timer core, its tick generator and its compare channels
`timescale 1ns/1ps

interface tick_if;
  import timer8_pkg::*;
  logic [2:0] clock_select_field; // 0 stops the timer
  logic async_clock_select; // count oscillator edges
  logic osc_level; // oscillator pin level
  logic enable; // low while power reduced
  logic tick; // one timer tick pulse
  modport gen (input clock_select_field, async_clock_select, osc_level, enable, output tick);
  modport core (output clock_select_field, async_clock_select, osc_level, enable, input tick);
endinterface : tick_if

interface chan_if;
  import timer8_pkg::*;
  logic tick; // timer tick pulse
  logic block; // matches suppressed this tick
  byte_t count; // counter value
  wave_mode_e mode; // waveform mode
  logic [1:0] com; // compare output mode
  logic force_cmp; // forced compare strobe
  logic wr; // software write of compare value
  byte_t wdata; // written value
  logic at_top; // counter equals top
  logic dir_down; // counting down
  byte_t cmp_active; // value used by comparator
  byte_t cmp_buffer; // value seen by software
  logic match; // qualified match pulse
  logic oc; // compare output state
  modport chan (input tick, block, count, mode, com, force_cmp, wr, wdata, at_top,
    dir_down, output cmp_active, cmp_buffer, match, oc);
  modport core (output tick, block, count, mode, com, force_cmp, wr, wdata, at_top,
    dir_down, input cmp_active, cmp_buffer, match, oc);
endinterface : chan_if

// ==== verilog/tick_gen.sv ====
// timer tick source: clock select, oscillator edge detect and prescaler
`timescale 1ns/1ps
`include "timer8_consts.svh"

module tick_gen (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // core side
  tick_if.gen tk
);
  import timer8_pkg::*;

  tick_state_s st_reg; // registered state
  tick_state_s st_next; // next state
  logic src; // one source pulse
  logic [9:0] tap; // selected divisor mask

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    st_next.osc_prev = tk.osc_level;
    // io clock by default, oscillator rising edges when async
    src = tk.async_clock_select ? (tk.osc_level & ~st_reg.osc_prev) : 1'b1;
    unique case (tk.clock_select_field)
      3'd1: tap = `PS_MASK_1;
      3'd2: tap = `PS_MASK_8;
      3'd3: tap = `PS_MASK_32;
      3'd4: tap = `PS_MASK_64;
      3'd5: tap = `PS_MASK_128;
      3'd6: tap = `PS_MASK_256;
      3'd7: tap = `PS_MASK_1024;
      default: tap = `PS_MASK_1;
    endcase
    st_next.tick = 1'b0;
    // stopped when no source chosen or power reduced
    if (tk.enable && (tk.clock_select_field != 3'd0) && src) begin
      st_next.prescale = st_reg.prescale + 10'h001;
      st_next.tick = ((st_reg.prescale & tap) == tap);
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tk.tick = st_reg.tick;

endmodule : tick_gen

// ==== verilog/compare_channel.sv ====
// one compare channel: buffered compare value, matcher and output state
`timescale 1ns/1ps

module compare_channel #(
  parameter bit TOGGLE_IN_PWM = 1'b0 // channel may toggle in compare-top pwm
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // core side
  chan_if.chan ch
);
  import timer8_pkg::*;

  chan_state_s st_reg; // registered state
  chan_state_s st_next; // next state
  logic pwm; // any pwm mode
  logic tgl; // toggle allowed in pwm

  // qualified match: tick, equal, not blocked by count write
  assign ch.match = ch.tick & ~ch.block & (ch.count == st_reg.active);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    pwm = is_fast(ch.mode) | is_phase(ch.mode);
    tgl = TOGGLE_IN_PWM & ch.mode[2] & (ch.com == 2'd1);
    // software write: buffer always, active only without pwm
    if (ch.wr) begin
      st_next.buffer = ch.wdata;
      if (!pwm) begin
        st_next.active = ch.wdata;
      end
    end
    // pwm reload only at top of sequence
    if (pwm && ch.tick && ch.at_top) begin
      st_next.active = st_reg.buffer;
    end
    if (!pwm) begin
      // non pwm: match or force acts on output, com zero holds
      if (ch.match || ch.force_cmp) begin
        unique case (ch.com)
          2'd0: st_next.oc = st_reg.oc;
          2'd1: st_next.oc = ~st_reg.oc;
          2'd2: st_next.oc = 1'b0;
          2'd3: st_next.oc = 1'b1;
        endcase
      end
    end else if (is_fast(ch.mode)) begin
      // fast pwm: match then bottom action, bottom wins
      if (ch.match) begin
        if (ch.com[1]) begin
          st_next.oc = ch.com[0];
        end else if (tgl) begin
          st_next.oc = ~st_reg.oc;
        end
      end
      if (ch.tick && ch.at_top && ch.com[1]) begin
        st_next.oc = ~ch.com[0];
      end
    end else begin
      // phase correct: action depends on direction
      if (ch.match) begin
        if (ch.com[1]) begin
          st_next.oc = ch.com[0] ^ ch.dir_down;
        end else if (tgl) begin
          st_next.oc = ~st_reg.oc;
        end
      end
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ch.cmp_active = st_reg.active;
  assign ch.cmp_buffer = st_reg.buffer;
  assign ch.oc = st_reg.oc;

endmodule : compare_channel

// ==== verilog/async_timer8_compare_core.sv ====
// asynchronous 8-bit timer with two compare channels behind an apb slave
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "timer8_consts.svh"

module async_timer8_compare_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // oscillator pins
  input wire logic osc_pin_in,
  output logic osc_pin_out,
  // compare outputs
  output logic compare_out_a,
  output logic compare_out_b,
  // interrupt requests and service strobes
  output logic irq_overflow,
  output logic irq_match_a,
  output logic irq_match_b,
  input wire logic ack_overflow,
  input wire logic ack_match_a,
  input wire logic ack_match_b
);
  import timer8_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  core_state_s st_reg; // registered state
  core_state_s st_next; // next state
  tick_if tk (); // link to tick source
  chan_if cha (); // channel a link
  chan_if chb (); // channel b link
  logic setup; // apb setup phase
  logic access; // apb completing access
  logic wr; // completing write
  logic wr_ok; // write allowed (not power reduced)
  logic mapped; // address decodes
  logic tick; // timer tick pulse
  wave_mode_e mode; // waveform mode
  byte_t top; // top of sequence
  logic at_top; // counter at top
  logic at_bottom; // counter at bottom
  logic cnt_wr; // software write of count
  logic [2:0] set_f; // flag set events
  logic [2:0] clr_f; // flag clear events
  logic [31:0] rdata; // read mux value

  // ************************************************************
  // submodules
  // ************************************************************
  tick_gen u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tk(tk)
  );

  compare_channel #(.TOGGLE_IN_PWM(1'b1)) u_chan_a (
    .clk(clk),
    .rst_n(rst_n),
    .ch(cha)
  );

  compare_channel #(.TOGGLE_IN_PWM(1'b0)) u_chan_b (
    .clk(clk),
    .rst_n(rst_n),
    .ch(chb)
  );

  // ************************************************************
  // decode and counter status
  // ************************************************************
  assign setup = psel & ~penable;
  assign access = psel & penable & st_reg.pready;
  assign wr = access & pwrite;
  assign wr_ok = wr & ~st_reg.power_reduce;
  assign tick = tk.tick;
  // mode bits split over both controls
  assign mode = wave_mode_e'({st_reg.ctrl_b[`CB_WGM2], st_reg.ctrl_a[1:0]});
  assign top = top_is_cmp(mode) ? cha.cmp_active : `BYTE_MAX;
  assign at_top = (st_reg.count == top);
  assign at_bottom = (st_reg.count == `BYTE_ZERO);
  assign cnt_wr = wr_ok & (paddr == `OFF_COUNT);

  // ************************************************************
  // links to the tick source
  // ************************************************************
  assign tk.clock_select_field = st_reg.ctrl_b[2:0];
  assign tk.async_clock_select = st_reg.async_sel;
  assign tk.osc_level = osc_pin_in;
  assign tk.enable = ~st_reg.power_reduce;

  // ************************************************************
  // links to channel a
  // ************************************************************
  assign cha.tick = tick;
  assign cha.block = st_reg.block;
  assign cha.count = st_reg.count;
  assign cha.mode = mode;
  assign cha.com = st_reg.ctrl_a[`CA_COM_A_LO +: 2];
  assign cha.force_cmp = wr_ok & (paddr == `OFF_CONTROL_B) & pwdata[`CB_FOC_A];
  assign cha.wr = wr_ok & (paddr == `OFF_COMPARE_A);
  assign cha.wdata = pwdata[7:0];
  assign cha.at_top = at_top;
  assign cha.dir_down = st_reg.dir_down;

  // ************************************************************
  // links to channel b
  // ************************************************************
  assign chb.tick = tick;
  assign chb.block = st_reg.block;
  assign chb.count = st_reg.count;
  assign chb.mode = mode;
  assign chb.com = st_reg.ctrl_a[`CA_COM_B_LO +: 2];
  assign chb.force_cmp = wr_ok & (paddr == `OFF_CONTROL_B) & pwdata[`CB_FOC_B];
  assign chb.wr = wr_ok & (paddr == `OFF_COMPARE_B);
  assign chb.wdata = pwdata[7:0];
  assign chb.at_top = at_top;
  assign chb.dir_down = st_reg.dir_down;

  // ************************************************************
  // read mux
  // ************************************************************
  always_comb begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      `OFF_CONTROL_A: rdata[7:0] = st_reg.ctrl_a;
      `OFF_CONTROL_B: rdata[3:0] = st_reg.ctrl_b; // force bits read zero
      `OFF_COUNT: rdata[7:0] = st_reg.count;
      `OFF_COMPARE_A: rdata[7:0] = cha.cmp_buffer;
      `OFF_COMPARE_B: rdata[7:0] = chb.cmp_buffer;
      `OFF_FLAG: rdata[2:0] = st_reg.flags;
      `OFF_MASK: rdata[2:0] = st_reg.mask;
      `OFF_ASYNC: rdata[`AS_ASYNC_SEL] = st_reg.async_sel;
      `OFF_POWER: rdata[`PW_REDUCE] = st_reg.power_reduce;
      default: mapped = 1'b0;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    st_next = st_reg;
    set_f = 3'b000;
    clr_f = 3'b000;
    // apb: answer in the cycle after setup
    st_next.pready = setup;
    if (setup) begin
      st_next.prdata = rdata;
      st_next.pslverr = ~mapped;
    end
    // register writes
    if (wr_ok) begin
      unique case (paddr)
        `OFF_CONTROL_A: st_next.ctrl_a = pwdata[7:0];
        `OFF_CONTROL_B: st_next.ctrl_b = pwdata[3:0];
        `OFF_MASK: st_next.mask = pwdata[2:0];
        `OFF_ASYNC: st_next.async_sel = pwdata[`AS_ASYNC_SEL];
        `OFF_FLAG: clr_f = pwdata[2:0];
        default: ;
      endcase
    end
    // power reduce bit stays writable while the timer is off
    if (wr && (paddr == `OFF_POWER)) begin
      st_next.power_reduce = pwdata[`PW_REDUCE];
    end
    // a blocking tick consumes the block
    if (tick) begin
      st_next.block = 1'b0;
    end
    // counter sequence per mode
    if (tick) begin
      if (is_phase(mode)) begin
        if (st_reg.dir_down) begin
          if (at_bottom) begin
            st_next.dir_down = 1'b0;
            st_next.count = st_reg.count + 8'h01;
          end else begin
            st_next.count = st_reg.count - 8'h01;
          end
          set_f[`FL_OVERFLOW] = (st_reg.count == 8'h01);
        end else if (at_top) begin
          st_next.dir_down = 1'b1;
          st_next.count = st_reg.count - 8'h01;
        end else begin
          st_next.count = st_reg.count + 8'h01;
        end
      end else if ((mode == WM_CTC) || is_fast(mode)) begin
        st_next.count = at_top ? `BYTE_ZERO : st_reg.count + 8'h01;
        if (is_fast(mode)) begin
          set_f[`FL_OVERFLOW] = at_top;
        end else begin
          set_f[`FL_OVERFLOW] = (st_reg.count == `BYTE_MAX);
        end
      end else begin
        // normal and reserved codes: plain wrapping up-count
        st_next.count = st_reg.count + 8'h01;
        set_f[`FL_OVERFLOW] = (st_reg.count == `BYTE_MAX);
      end
    end
    // software count write wins and arms the block
    if (cnt_wr) begin
      st_next.count = pwdata[7:0];
      st_next.block = 1'b1;
    end
    // match flags from qualified matches
    set_f[`FL_MATCH_A] = cha.match;
    set_f[`FL_MATCH_B] = chb.match;
    // service strobes clear too
    clr_f = clr_f | {ack_match_b, ack_match_a, ack_overflow};
    // set wins over clear
    st_next.flags = (st_reg.flags & ~clr_f) | set_f;
    // requests gated by mask
    st_next.irq = st_next.flags & st_reg.mask;
    // crystal amplifier drive
    st_next.osc_out = ~osc_pin_in;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.power_reduce <= `RST_POWER_REDUCE;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign osc_pin_out = st_reg.osc_out;
  assign compare_out_a = cha.oc;
  assign compare_out_b = chb.oc;
  assign irq_overflow = st_reg.irq[`FL_OVERFLOW];
  assign irq_match_a = st_reg.irq[`FL_MATCH_A];
  assign irq_match_b = st_reg.irq[`FL_MATCH_B];

endmodule : async_timer8_compare_core

// ==== verif/timer8_monitor.sv ====
// checker of port relations of the 8-bit timer
`timescale 1ns/1ps

module timer8_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pins
  input wire logic osc_pin_in,
  input wire logic osc_pin_out,
  input wire logic compare_out_a,
  input wire logic irq_overflow,
  input wire logic irq_match_a,
  input wire logic ack_overflow
);
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready wider");
  property p_setup_answer; psel && !penable |=> pready; endproperty
  a_setup_answer: assert property (p_setup_answer) else $error("no answer");
  property p_ready_access; pready |-> psel && penable; endproperty
  a_ready_access: assert property (p_ready_access) else $error("stray pready");
  property p_err_unmapped; pready && paddr > 8'h20 |-> pslverr && prdata == 32'h0; endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("no error");
  property p_ok_mapped; pready && paddr <= 8'h20 && paddr[1:0] == 2'b00 |-> !pslverr; endproperty
  a_ok_mapped: assert property (p_ok_mapped) else $error("false error");
  property p_upper_zero; pready |-> prdata[31:8] == 24'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper bits set");
  property p_osc_inv; 1'b1 |=> osc_pin_out == !$past(osc_pin_in); endproperty
  a_osc_inv: assert property (p_osc_inv) else $error("osc out wrong");
  property p_reset_quiet; $rose(rst_n) |-> !pready && !irq_overflow && !compare_out_a; endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("busy at reset");
  property p_ack_clears; ack_overflow && irq_overflow |-> ##[1:2] !irq_overflow; endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack kept irq");
  c_err: cover property (pslverr);
  c_irq_a: cover property ($rose(irq_match_a));
  c_out_a: cover property ($rose(compare_out_a));
endmodule : timer8_monitor

bind async_timer8_compare_core timer8_monitor mon (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out), .compare_out_a(compare_out_a),
  .irq_overflow(irq_overflow), .irq_match_a(irq_match_a), .ack_overflow(ack_overflow));

// ==== verif/tb_top.sv ====
// self-checking bench of the 8-bit timer over apb
`timescale 1ns/1ps
`include "timer8_consts.svh"

module tb_top;
  // ****
  // signals and design
  // ****
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, osc_pin_in = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic pready, pslverr, er, osc_pin_out, cmp_a, cmp_b, irq_ov, irq_a, irq_b;
  logic ack_ov = 1'b0, ack_a = 1'b0, ack_b = 1'b0;
  int err_total = 0;
  int check_count = 0;
  always #12.5 clk = ~clk;
  async_timer8_compare_core uut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_pin_in(osc_pin_in), .osc_pin_out(osc_pin_out),
    .compare_out_a(cmp_a), .compare_out_b(cmp_b), .irq_overflow(irq_ov),
    .irq_match_a(irq_a), .irq_match_b(irq_b), .ack_overflow(ack_ov),
    .ack_match_a(ack_a), .ack_match_b(ack_b));
  // ****
  // tasks
  // ****
  // one apb transfer, entered just after an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the watchdog ends a wait for the answer
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask : rdc
  // start with clock select one, stop after n idle cycles
  task automatic run(input int n);
    wr(`OFF_CONTROL_B, 8'h01);
    repeat (n) @(posedge clk);
    wr(`OFF_CONTROL_B, 8'h00);
  endtask : run
  task automatic tally_and_finish();
    if (err_total == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // ****
  // tests
  // ****
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a <= 32; a += 4) rdc(8'(a), 32'h0);
    apb(1'b0, 8'h24, 8'h00);
    chk(32'(er), 32'h1);
    // stopped timer keeps a written count, write blocks next match
    wr(`OFF_COMPARE_A, 8'h40);
    wr(`OFF_COUNT, 8'h40);
    repeat (8) @(posedge clk);
    rdc(`OFF_COUNT, 32'h40);
    run(0);
    rdc(`OFF_FLAG, 32'h0);
    // power reduce ignores count writes
    apb(1'b0, `OFF_COUNT, 8'h00);
    v = rd;
    wr(`OFF_POWER, 8'h01);
    wr(`OFF_COUNT, ~v[7:0]);
    wr(`OFF_POWER, 8'h00);
    rdc(`OFF_COUNT, v);
    // wrap, overflow and both matches, b masked; run(6) gives nine ticks
    wr(`OFF_MASK, 8'h03);
    wr(`OFF_COMPARE_A, 8'h01);
    wr(`OFF_COMPARE_B, 8'h02);
    wr(`OFF_COUNT, 8'hfc);
    run(6);
    rdc(`OFF_FLAG, 32'h7);
    rdc(`OFF_COUNT, 32'h05);
    chk(32'({irq_b, irq_a, irq_ov}), 32'h3);
    ack_ov <= 1'b1;
    ack_b <= 1'b1;
    @(posedge clk);
    ack_ov <= 1'b0;
    ack_b <= 1'b0;
    @(posedge clk);
    rdc(`OFF_FLAG, 32'h2);
    wr(`OFF_FLAG, 8'h02);
    rdc(`OFF_FLAG, 32'h0);
    chk(32'({irq_b, irq_a, irq_ov}), 32'h0);
    // clear-on-compare and fast pwm with compare top
    wr(`OFF_COMPARE_A, 8'h03);
    for (int m = 0; m < 2; m++) begin
      wr(`OFF_CONTROL_A, m ? 8'h03 : 8'h02);
      wr(`OFF_COUNT, 8'h00);
      wr(`OFF_CONTROL_B, m ? 8'h09 : 8'h01);
      repeat (6) begin
        apb(1'b0, `OFF_COUNT, 8'h00);
        chk(32'(rd <= 32'h3), 32'h1);
      end
      wr(`OFF_CONTROL_B, m ? 8'h08 : 8'h00);
    end
    rdc(`OFF_CONTROL_B, 32'h08);
    wr(`OFF_COMPARE_B, 8'h55);
    rdc(`OFF_COMPARE_B, 32'h55);
    // forced compare toggles outputs, no flag
    wr(`OFF_CONTROL_B, 8'h00);
    wr(`OFF_FLAG, 8'h07);
    chk(32'({cmp_b, cmp_a}), 32'h0);
    wr(`OFF_CONTROL_A, 8'h50);
    wr(`OFF_CONTROL_B, 8'hc0);
    chk(32'({cmp_b, cmp_a}), 32'h3);
    rdc(`OFF_FLAG, 32'h0);
    wr(`OFF_CONTROL_A, 8'h00);
    wr(`OFF_CONTROL_B, 8'hc0);
    chk(32'({cmp_b, cmp_a}), 32'h3);
    // phase correct, compare top 3: six ticks go 0 up to 3 and back to 0
    wr(`OFF_COMPARE_A, 8'h03);
    wr(`OFF_COMPARE_B, 8'h10);
    wr(`OFF_FLAG, 8'h07);
    wr(`OFF_CONTROL_A, 8'h01);
    wr(`OFF_COUNT, 8'h00);
    wr(`OFF_CONTROL_B, 8'h09);
    repeat (3) @(posedge clk);
    wr(`OFF_CONTROL_B, 8'h08);
    rdc(`OFF_COUNT, 32'h0);
    rdc(`OFF_FLAG, 32'h3);
    wr(`OFF_CONTROL_A, 8'h00);
    // oscillator source: five rising edges give five ticks
    wr(`OFF_ASYNC, 8'h08);
    wr(`OFF_COUNT, 8'h00);
    wr(`OFF_CONTROL_B, 8'h01);
    repeat (10) @(posedge clk);
    rdc(`OFF_COUNT, 32'h0);
    repeat (10) begin
      repeat (4) @(posedge clk);
      osc_pin_in <= ~osc_pin_in;
    end
    repeat (8) @(posedge clk);
    wr(`OFF_CONTROL_B, 8'h00);
    rdc(`OFF_COUNT, 32'h5);
    tally_and_finish();
  end
  // hang guard, well above the test length
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("BAD %0t timeout", $time);
    tally_and_finish();
  end
endmodule : tb_top
